/* logic/irq_tb_defs.vh */
// constants for the touch/timer/time base interrupt block
// assumes an 8-bit register port and one 100 MHz clock
`ifndef IRQ_TB_DEFS_VH
`define IRQ_TB_DEFS_VH
// register addresses on the plain port
`define ADDR_IRQ_CTRL0    4'h0
`define ADDR_IRQ_CTRL1    4'h1
`define ADDR_TB_CTRL      4'h2
`define ADDR_TMR_CTRL     4'h3
`define ADDR_STATUS       4'h4
// first interrupt control register bits
`define C0_GIE            0
`define C0_TOUCH_EN       2
`define C0_TIMER_EN       3
`define C0_TOUCH_FLAG     5
`define C0_TIMER_FLAG     6
// second interrupt control register bits
`define C1_TB_EN          1
`define C1_TB_FLAG        5
// time base control fields
`define TB_SEL_LO         4
`define TB_SEL_HI         5
// timer control: clock source select bit
`define TMR_CLK_SEL       3
// status register bits
`define ST_STACK_FULL     0
`define ST_SLEEP          1
// vectors for each source
`define VEC_TOUCH         8'h08
`define VEC_TIMER         8'h0c
`define VEC_TB            8'h10
// reset values
`define RST_BYTE          8'h00
`define RST_DIV           13'h0000
`endif

/* logic/tb_divider.v */
// time base divider: counts input clock enables, pulses on time-out
// assumes the input tick is a one-cycle enable in the single clock domain
`timescale 1ns/10ps
`default_nettype none
`include "irq_tb_defs.vh"
module tb_divider #(
    parameter WIDTH = 13                      // enough for 8192 periods
) (
    // clock and reset
    input  wire             ref_clk_in,
    input  wire             rst_n_in,
    // control
    input  wire             tick_in,          // one input clock period
    input  wire [1:0]       period_sel_in,    // time-out select
    // result
    output reg              overflow_out      // one-cycle pulse
);
    reg [WIDTH-1:0] count_reg;                // free-running divider

    // terminal count for 1024 << sel
    function [WIDTH-1:0] last_count;
        input [1:0] sel;
        begin
            last_count = ({{(WIDTH-1){1'b0}}, 1'b1} << (4'ha + {2'b00, sel})) - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    // divider counts while ticks arrive; wraps at the selected period
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg    <= `RST_DIV;
            overflow_out <= 1'b0;
        end else begin
            overflow_out <= 1'b0;
            if (tick_in) begin
                // >= so a shorter period chosen mid-count wraps at once
                if (count_reg >= last_count(period_sel_in)) begin // [RULE9]
                    count_reg    <= `RST_DIV;
                    overflow_out <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // tb_divider
`default_nettype wire

/* logic/irq_timebase.v */
// interrupt request flags, enables and time base for three sources
// assumes the core gives one-cycle event pulses and takes vectors at once
// How it works
// RULE1: touch overflow sets flag; vector needs both enables
// RULE2: touch service clears its flag and global
// RULE3: timer overflow sets flag; vector needs both enables
// RULE4: timer service clears its flag and global
// RULE5: time base overflow sets flag; gated vector
// RULE6: time base service clears flag and global
// RULE7: no vector call while the stack is full
// RULE8: clock select picks system or sub clock
// RULE9: period select gives 1024..8192 input periods
// RULE10: unused time base control bits read zero
// RULE11: rising flag wakes from sleep, enables ignored
// RULE12: software presets flag to block wake-up
// RULE13: flags stay set until service or clear
// RULE14: only program counter pushed on entry
// RULE15: interrupt return pops and sets global enable
// RULE16: plain return pops, global stays zero
// RULE17: software avoids calls inside service routines
// RULE18: global enable clear blocks all servicing
// RULE19: first control register bit layout, reset zero
// RULE20: second control register bit layout, reset zero
// RULE21: fixed priority, distinct vector per source
`timescale 1ns/10ps
`default_nettype none
`include "irq_tb_defs.vh"
module irq_timebase (
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       rst_n_in,
    // register port
    input  wire [3:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output reg  [7:0] rdata_out,
    // event sources
    input  wire       touch_overflow_in,   // time slot counter overflow
    input  wire       timer_overflow_in,   // timer/event counter overflow
    input  wire       sys_tick_in,         // system clock enable
    input  wire       sub_tick_in,         // sub clock enable
    // core sequencer side
    input  wire       stack_full_in,       // no room for a push
    input  wire       sleep_in,            // core in sleep or idle
    input  wire       ret_in,              // plain return executed
    input  wire       irq_ret_in,          // return from interrupt executed
    output reg        vector_call_out,     // one-cycle call request
    output reg  [7:0] vector_addr_out,     // target vector
    output reg        push_pc_out,         // push program counter only
    output reg        pop_pc_out,          // pop program counter
    output reg        wake_out             // one-cycle wake-up pulse
);
    // register state
    reg       gie_reg;          // global enable
    reg       touch_en_reg;     // touch enable
    reg       timer_en_reg;     // timer enable
    reg       tb_en_reg;        // time base enable
    reg       touch_flag_reg;   // touch request
    reg       timer_flag_reg;   // timer request
    reg       tb_flag_reg;      // time base request
    reg [1:0] tb_sel_reg;       // time base period select
    reg       clk_sel_reg;      // time base clock source
    reg       spare_tc_reg;     // timer control bit 0 kept
    reg [2:0] flags_prev_reg;   // last flags for edge detect

    // next values
    reg       gie_next;
    reg       touch_flag_next;
    reg       timer_flag_next;
    reg       tb_flag_next;

    // service selection
    wire      tb_ovf;           // divider time-out pulse
    wire      tb_tick;          // selected input clock enable
    wire      want_touch;
    wire      want_timer;
    wire      want_tb;
    wire      take;             // a call goes out next cycle
    wire      serve_touch;
    wire      serve_timer;
    wire      serve_tb;
    wire [2:0] flags_now;
    wire      wr0;
    wire      wr1;

    // time base input clock source
    assign tb_tick = clk_sel_reg ? sub_tick_in : sys_tick_in; // [RULE8]

    tb_divider #(
        .WIDTH (13)
    ) u_div (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .tick_in       (tb_tick),
        .period_sel_in (tb_sel_reg),
        .overflow_out  (tb_ovf)
    );

    // request gating by both enables and stack room
    assign want_touch = touch_flag_reg & touch_en_reg;  // [RULE1]
    assign want_timer = timer_flag_reg & timer_en_reg;  // [RULE3]
    assign want_tb    = tb_flag_reg & tb_en_reg;        // [RULE5]
    // global enable low blocks everything; full stack makes it wait
    assign take = gie_reg & ~stack_full_in & (want_touch | want_timer | want_tb); // [RULE18] [RULE7]
    // fixed order: touch, then timer, then time base
    assign serve_touch = take & want_touch;                       // [RULE21]
    assign serve_timer = take & ~want_touch & want_timer;         // [RULE21]
    assign serve_tb    = take & ~want_touch & ~want_timer & want_tb; // [RULE21]

    assign wr0 = wr_in & (addr_in == `ADDR_IRQ_CTRL0);
    assign wr1 = wr_in & (addr_in == `ADDR_IRQ_CTRL1);

    // flag and global enable next state; event set wins over flag clear, service clear over return set
    always @* begin
        gie_next        = gie_reg;
        touch_flag_next = touch_flag_reg;
        timer_flag_next = timer_flag_reg;
        tb_flag_next    = tb_flag_reg;
        // software writes first
        if (wr0) begin
            gie_next        = wdata_in[`C0_GIE];
            touch_flag_next = wdata_in[`C0_TOUCH_FLAG];
            timer_flag_next = wdata_in[`C0_TIMER_FLAG];
        end
        if (wr1) begin
            tb_flag_next = wdata_in[`C1_TB_FLAG];
        end
        // return handling
        if (irq_ret_in) begin
            gie_next = 1'b1; // [RULE15]
        end
        // plain return leaves global enable untouched [RULE16]
        // service clears the served flag and global enable
        if (serve_touch) begin
            touch_flag_next = 1'b0; // [RULE2]
        end
        if (serve_timer) begin
            timer_flag_next = 1'b0; // [RULE4]
        end
        if (serve_tb) begin
            tb_flag_next = 1'b0; // [RULE6]
        end
        if (take) begin
            gie_next = 1'b0; // [RULE2] [RULE4] [RULE6]
        end
        // events last so a same-cycle clear never loses them
        if (touch_overflow_in) begin
            touch_flag_next = 1'b1; // [RULE1] [RULE13]
        end
        if (timer_overflow_in) begin
            timer_flag_next = 1'b1; // [RULE3] [RULE13]
        end
        if (tb_ovf) begin
            tb_flag_next = 1'b1; // [RULE5] [RULE13]
        end
    end

    assign flags_now = {tb_flag_reg, timer_flag_reg, touch_flag_reg};

    // register and sequencer state
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gie_reg         <= 1'b0;
            touch_en_reg    <= 1'b0;
            timer_en_reg    <= 1'b0;
            tb_en_reg       <= 1'b0;
            touch_flag_reg  <= 1'b0;
            timer_flag_reg  <= 1'b0;
            tb_flag_reg     <= 1'b0;
            tb_sel_reg      <= 2'b00;
            clk_sel_reg     <= 1'b0;
            spare_tc_reg    <= 1'b0;
            flags_prev_reg  <= 3'b000;
            vector_call_out <= 1'b0;
            vector_addr_out <= `RST_BYTE;
            push_pc_out     <= 1'b0;
            pop_pc_out      <= 1'b0;
            wake_out        <= 1'b0;
        end else begin
            gie_reg        <= gie_next;
            touch_flag_reg <= touch_flag_next;
            timer_flag_reg <= timer_flag_next;
            tb_flag_reg    <= tb_flag_next;
            flags_prev_reg <= flags_now;
            // enable bits: disabling keeps pending flags [RULE13]
            if (wr0) begin
                touch_en_reg <= wdata_in[`C0_TOUCH_EN]; // [RULE19]
                timer_en_reg <= wdata_in[`C0_TIMER_EN]; // [RULE19]
            end
            if (wr1) begin
                tb_en_reg <= wdata_in[`C1_TB_EN]; // [RULE20]
            end
            if (wr_in && addr_in == `ADDR_TB_CTRL) begin
                tb_sel_reg <= wdata_in[`TB_SEL_HI:`TB_SEL_LO]; // [RULE9]
            end
            if (wr_in && addr_in == `ADDR_TMR_CTRL) begin
                clk_sel_reg  <= wdata_in[`TMR_CLK_SEL]; // [RULE8]
                spare_tc_reg <= wdata_in[0];
            end
            // call request with only the program counter pushed
            vector_call_out <= take;
            push_pc_out     <= take; // [RULE14]
            if (serve_touch) begin
                vector_addr_out <= `VEC_TOUCH; // [RULE21]
            end else if (serve_timer) begin
                vector_addr_out <= `VEC_TIMER; // [RULE21]
            end else if (serve_tb) begin
                vector_addr_out <= `VEC_TB; // [RULE21]
            end
            // both returns pop the program counter
            pop_pc_out <= ret_in | irq_ret_in; // [RULE15] [RULE16]
            // wake on any rising flag, regardless of enables
            wake_out <= sleep_in & (|(flags_now & ~flags_prev_reg)); // [RULE11] [RULE12]
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= `RST_BYTE;
        end else if (rd_in) begin
            case (addr_in)
                `ADDR_IRQ_CTRL0: begin
                    rdata_out <= {1'b0, timer_flag_reg, touch_flag_reg, 1'b0,
                                  timer_en_reg, touch_en_reg, 1'b0, gie_reg}; // [RULE19]
                end
                `ADDR_IRQ_CTRL1: begin
                    rdata_out <= {2'b00, tb_flag_reg, 3'b000, tb_en_reg, 1'b0}; // [RULE20]
                end
                `ADDR_TB_CTRL: begin
                    rdata_out <= {2'b00, tb_sel_reg, 4'h0}; // [RULE10]
                end
                `ADDR_TMR_CTRL: begin
                    rdata_out <= {4'h0, clk_sel_reg, 2'b00, spare_tc_reg};
                end
                `ADDR_STATUS: begin
                    rdata_out <= {6'h00, sleep_in, stack_full_in};
                end
                default: begin
                    rdata_out <= `RST_BYTE;
                end
            endcase
        end else begin
            rdata_out <= `RST_BYTE;
        end
    end
endmodule // irq_timebase
`default_nettype wire

/* testbench/irq_timebase_assertions.sv */
// port-level checker for the interrupt and time base block
// assumes one clock domain; bound to the design top below
`timescale 1ns/10ps
`default_nettype none
`include "irq_tb_defs.vh"
module irq_timebase_assertions (
    // clock, reset, register port
    input wire logic       ref_clk_in,
    input wire logic       rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // core side
    input wire logic       stack_full_in,
    input wire logic       sleep_in,
    input wire logic       ret_in,
    input wire logic       irq_ret_in,
    input wire logic       vector_call_out,
    input wire logic [7:0] vector_addr_out,
    input wire logic       push_pc_out,
    input wire logic       pop_pc_out,
    input wire logic       wake_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // only the pc is pushed, always with the call
    chk_push_with_call: assert property (push_pc_out == vector_call_out)
        else $error("push and call differ");
    // both return kinds pop one cycle later
    chk_ret_pops: assert property ((ret_in || irq_ret_in) |=> pop_pc_out)
        else $error("return without pop");
    chk_pop_cause: assert property (pop_pc_out |-> $past(ret_in || irq_ret_in))
        else $error("pop without return");
    // a full stack holds any call back
    chk_full_blocks: assert property (stack_full_in |=> !vector_call_out)
        else $error("call while stack full");
    // service clears global, so no call follows at once
    chk_call_single: assert property (vector_call_out |=> !vector_call_out)
        else $error("back to back calls");
    chk_vec_legal: assert property (vector_call_out |-> vector_addr_out inside {8'h08, 8'h0c, 8'h10})
        else $error("unknown vector");
    chk_vec_hold: assert property (!vector_call_out |-> $stable(vector_addr_out))
        else $error("vector moved without call");
    // unused time base control bits read zero
    chk_tb_unused: assert property (rd_in && addr_in == `ADDR_TB_CTRL |=>
        rdata_out[7:6] == 2'h0 && rdata_out[3:0] == 4'h0) else $error("unused bits set");
    chk_wake_sleep: assert property (wake_out |-> $past(sleep_in))
        else $error("wake while awake");
endmodule // irq_timebase_assertions
bind irq_timebase irq_timebase_assertions chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out), .stack_full_in(stack_full_in),
    .sleep_in(sleep_in), .ret_in(ret_in), .irq_ret_in(irq_ret_in), .vector_call_out(vector_call_out),
    .vector_addr_out(vector_addr_out), .push_pc_out(push_pc_out), .pop_pc_out(pop_pc_out),
    .wake_out(wake_out));
`default_nettype wire

/* testbench/core_seq_model.sv */
// core sequencer model: takes calls, returns after a short service
// assumes one free stack level; the bench may occupy it with fill_in
`timescale 1ns/10ps
`default_nettype none
module core_seq_model (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    // control from the bench
    input  wire logic call_in,
    input  wire logic fill_in,
    input  wire logic use_irq_ret_in,
    // towards the design
    output wire logic stack_full_out,
    output var  logic ret_out,
    output var  logic irq_ret_out
);
    logic [1:0] cnt_reg;    // service length
    logic       served_reg; // pc occupies the free level
    // routine never calls again, so one level suffices
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            served_reg <= 1'h0;
            cnt_reg <= 2'h0;
            ret_out <= 1'h0;
            irq_ret_out <= 1'h0;
        end else begin
            ret_out <= 1'h0;
            irq_ret_out <= 1'h0;
            if (call_in) begin // pc pushed
                served_reg <= 1'h1;
                cnt_reg <= 2'h3;
            end else if (cnt_reg != 2'h0) begin
                cnt_reg <= cnt_reg - 2'h1;
            end else if (served_reg) begin
                served_reg <= 1'h0;
                irq_ret_out <= use_irq_ret_in;
                ret_out <= !use_irq_ret_in;
            end
        end
    end
    assign stack_full_out = fill_in | served_reg;
endmodule // core_seq_model
`default_nettype wire

/* testbench/test_irq_timebase.sv */
// self-checking bench for the interrupt and time base block
// assumes the core model answers each call with a plain or interrupt return
`timescale 1ns/10ps
`default_nettype none
`include "irq_tb_defs.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("unexpected %s exp %0h got %0h", n, e, g); fail_count++; end end
module test_irq_timebase;
    logic       ref_clk_in = 1'h0, rst_n_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, d, v;
    logic       touch_overflow_in = 1'h0, timer_overflow_in = 1'h0, sys_tick_in = 1'h0;
    logic       sub_tick_in = 1'h0, sub_on = 1'h0, sleep_in = 1'h0, fill = 1'h0, use_irq_ret = 1'h0;
    wire        stack_full_in, ret_in, irq_ret_in, vector_call_out, push_pc_out, pop_pc_out, wake_out;
    wire  [7:0] rdata_out, vector_addr_out;
    logic [7:0] mask [3] = '{8'h6c, 8'h22, 8'h30}; // writable bits per register except the global enable
    logic [7:0] vq [$];                            // vectors seen, in order
    int         cq [$];                            // cycle of each call
    int         fail_count = 0, n_checks = 0, cyc = 0, wake_cnt = 0, t0, c;
    irq_timebase DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .touch_overflow_in(touch_overflow_in), .timer_overflow_in(timer_overflow_in),
        .sys_tick_in(sys_tick_in), .sub_tick_in(sub_tick_in), .stack_full_in(stack_full_in),
        .sleep_in(sleep_in), .ret_in(ret_in), .irq_ret_in(irq_ret_in), .vector_call_out(vector_call_out),
        .vector_addr_out(vector_addr_out), .push_pc_out(push_pc_out), .pop_pc_out(pop_pc_out),
        .wake_out(wake_out));
    core_seq_model core (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .call_in(vector_call_out),
        .fill_in(fill), .use_irq_ret_in(use_irq_ret), .stack_full_out(stack_full_in), .ret_out(ret_in),
        .irq_ret_out(irq_ret_in));
    initial forever #5 ref_clk_in = ~ref_clk_in;
    // monitor: log calls and wakes, half-rate sub clock, hang guard
    always @(posedge ref_clk_in) begin
        cyc++;
        if (vector_call_out === 1'h1) begin
            vq.push_back(vector_addr_out);
            cq.push_back(cyc);
        end
        if (wake_out === 1'h1) wake_cnt++;
        sub_tick_in <= sub_on & ~sub_tick_in;
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge ref_clk_in);
        wr_in <= 1'h1;
        addr_in <= a;
        wdata_in <= x;
        @(posedge ref_clk_in);
        wr_in <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        rd_in <= 1'h1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'h0;
        #1 `CHK("rdata", e, rdata_out)
    endtask
    task automatic ev(input logic t, input logic m);
        @(posedge ref_clk_in);
        touch_overflow_in <= t;
        timer_overflow_in <= m;
        @(posedge ref_clk_in);
        touch_overflow_in <= 1'h0;
        timer_overflow_in <= 1'h0;
    endtask
    // next logged call, unknown if none comes in time
    task automatic get_call(input int bound);
        repeat (bound) if (vq.size() == 0) @(posedge ref_clk_in);
        v = (vq.size() != 0) ? vq.pop_front() : 8'hxx;
        c = (cq.size() != 0) ? cq.pop_front() : 0;
    endtask
    initial begin
        void'($urandom(17));
        repeat (4) @(posedge ref_clk_in);
        rst_n_in <= 1'h1;
        for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
        for (int i = 0; i < 12; i++) begin
            d = 8'($urandom);
            // global kept off so no call can clear a flag before the read
            wr(4'(i % 3), d & 8'hfe);
            rd(4'(i % 3), d & mask[i % 3]);
        end
        for (int a = 0; a < 3; a++) wr(4'(a), 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        // touch served, plain return keeps global off
        wr(`ADDR_IRQ_CTRL0, 8'h05);
        ev(1'h1, 1'h0);
        get_call(10);
        `CHK("vec", `VEC_TOUCH, v)
        repeat (12) @(posedge ref_clk_in);
        rd(`ADDR_IRQ_CTRL0, 8'h04);
        use_irq_ret <= 1'h1;
        wr(`ADDR_IRQ_CTRL0, 8'h09);
        ev(1'h0, 1'h1);
        get_call(10);
        `CHK("vec", `VEC_TIMER, v)
        repeat (12) @(posedge ref_clk_in);
        rd(`ADDR_IRQ_CTRL0, 8'h09);
        // pending flag survives global off and a full stack
        wr(`ADDR_IRQ_CTRL0, 8'h08);
        ev(1'h0, 1'h1);
        repeat (10) @(posedge ref_clk_in);
        rd(`ADDR_IRQ_CTRL0, 8'h48);
        fill <= 1'h1;
        wr(`ADDR_IRQ_CTRL0, 8'h49);
        repeat (10) @(posedge ref_clk_in);
        rd(`ADDR_IRQ_CTRL0, 8'h49);
        `CHK("calls", 0, vq.size())
        fill <= 1'h0;
        get_call(10);
        `CHK("vec", `VEC_TIMER, v)
        // simultaneous requests, touch first
        wr(`ADDR_IRQ_CTRL0, 8'h0d);
        ev(1'h1, 1'h1);
        get_call(10);
        `CHK("vec", `VEC_TOUCH, v)
        get_call(20);
        `CHK("vec", `VEC_TIMER, v)
        // wake on rising flag only; a flag still set from the first event blocks it
        wr(`ADDR_IRQ_CTRL0, 8'h00);
        sleep_in <= 1'h1;
        ev(1'h1, 1'h0);
        repeat (3) @(posedge ref_clk_in);
        `CHK("wake", 1, wake_cnt)
        ev(1'h1, 1'h0);
        repeat (3) @(posedge ref_clk_in);
        `CHK("wake", 1, wake_cnt)
        sleep_in <= 1'h0;
        // time base periods; first interval after a change is dropped
        wr(`ADDR_IRQ_CTRL0, 8'h01);
        wr(`ADDR_IRQ_CTRL1, 8'h02);
        sys_tick_in <= 1'h1;
        for (int s = 0; s < 5; s++) begin
            if (s == 4) wr(`ADDR_TMR_CTRL, 8'h08);
            sub_on <= (s == 4);
            wr(`ADDR_TB_CTRL, 8'(s % 4) << 4);
            vq.delete();
            cq.delete();
            get_call(17000);
            t0 = c;
            get_call(17000);
            `CHK("vec", `VEC_TB, v)
            `CHK("period", (s == 4) ? 2048 : 1024 << s, c - t0)
        end
        final_report();
    end
endmodule // test_irq_timebase
`default_nettype wire
